/* rtl/crg_map.svh */
// Constants for the CPU register and addressing datapath.
// Assumes inclusion by bare name from crg_ea, crg_mul, crg_core and the bench.
`ifndef CRG_MAP_SVH
`define CRG_MAP_SVH
// Register offsets, word aligned
`define CRG_OFF_ACC 5'h00
`define CRG_OFF_IDX 5'h04
`define CRG_OFF_SP 5'h08
`define CRG_OFF_PC 5'h0c
`define CRG_OFF_CCR 5'h10
`define CRG_OFF_CMD 5'h14
`define CRG_OFF_OPND 5'h18
`define CRG_OFF_EA 5'h1c
// Reset values and fixed bits
`define CRG_SP_RESET 16'h00ff
`define CRG_SP_FIXED 10'h003
`define CRG_CCR_FIXED 3'h7
`define CRG_PC_MASK 16'h3fff
// Condition code bit positions
`define CRG_CCR_H 4
`define CRG_CCR_I 3
`define CRG_CCR_N 2
`define CRG_CCR_Z 1
`define CRG_CCR_C 0
// Multiply length in internal clocks
`define CRG_MUL_CYCLES 4'd11
`endif

/* rtl/crg_pkg.sv */
// Types for the CPU register and addressing datapath.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package crg_pkg;
   // Commands written to the command register
   typedef enum logic [3:0] {
      CRG_CMD_NOP = 4'h0,
      CRG_CMD_ADD = 4'h1,
      CRG_CMD_ADC = 4'h2,
      CRG_CMD_SUB = 4'h3,
      CRG_CMD_AND = 4'h4,
      CRG_CMD_LDA = 4'h5,
      CRG_CMD_MUL = 4'h6,
      CRG_CMD_RSP = 4'h7,
      CRG_CMD_PUSH = 4'h8,
      CRG_CMD_PULL = 4'h9,
      CRG_CMD_EA = 4'ha,
      CRG_CMD_BRANCH = 4'hb,
      CRG_CMD_FETCH = 4'hc,
      CRG_CMD_JUMP = 4'hd,
      CRG_CMD_IRQ = 4'he,
      CRG_CMD_RTI = 4'hf
   } crg_cmd_t;
   // Addressing modes
   typedef enum logic [2:0] {
      CRG_AM_INH = 3'h0,
      CRG_AM_IMM = 3'h1,
      CRG_AM_DIR = 3'h2,
      CRG_AM_EXT = 3'h3,
      CRG_AM_IX0 = 3'h4,
      CRG_AM_IX1 = 3'h5,
      CRG_AM_IX2 = 3'h6,
      CRG_AM_REL = 3'h7
   } crg_mode_t;
   typedef enum logic [1:0] {
      CRG_ST_IDLE = 2'b00,
      CRG_ST_MUL = 2'b01
   } crg_state_t;
endpackage : crg_pkg
`default_nettype wire

/* rtl/crg_ea.sv */
// Effective address and instruction length for the eight addressing modes.
// Assumes operand bytes are already gathered by the caller.
`include "crg_map.svh"
`default_nettype none
module crg_ea
   import crg_pkg::*;
(
   // Mode and operands
   input wire crg_mode_t mode,
   input wire logic [7:0] index,
   input wire logic [7:0] byte1,
   input wire logic [7:0] byte2,
   input wire logic [15:0] next_pc,
   input wire logic cond,
   // Results
   output logic [15:0] eff_addr,
   output logic [1:0] length
);
   // Address and length per mode
   always_comb begin
      eff_addr = 16'h0000;
      length = 2'd1;
      case (mode)
         CRG_AM_INH: length = 2'd1;
         CRG_AM_IMM: length = 2'd2;
         CRG_AM_DIR: begin
            length = 2'd2;
            eff_addr = {8'h00, byte1};
         end
         CRG_AM_EXT: begin
            length = 2'd3;
            eff_addr = {byte1, byte2};
         end
         CRG_AM_IX0: begin
            length = 2'd1;
            eff_addr = {8'h00, index};
         end
         CRG_AM_IX1: begin
            length = 2'd2;
            eff_addr = {7'h00, {1'b0, index} + {1'b0, byte1}};
         end
         CRG_AM_IX2: begin
            length = 2'd3;
            eff_addr = {byte1, byte2} + {8'h00, index};
         end
         CRG_AM_REL: begin
            length = 2'd2;
            // Signed offset from the following address
            eff_addr = cond ? next_pc + {{8{byte1[7]}}, byte1} : next_pc;
         end
         default: length = 2'd1;
      endcase
   end
endmodule : crg_ea
`default_nettype wire

/* rtl/crg_mul.sv */
// Add-and-shift unsigned multiplier, one step per clock.
// Assumes start is a single-cycle pulse while idle.
`include "crg_map.svh"
`default_nettype none
module crg_mul
   import crg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Operands
   input wire logic start,
   input wire logic [7:0] mcand,
   input wire logic [7:0] mplier,
   // Result
   output logic busy,
   output logic done,
   output logic [15:0] product
);
   logic [3:0] count;
   logic [7:0] cand;
   // Chain of add and shift, padded to the fixed length
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count <= 4'd0;
         busy <= 1'b0;
         done <= 1'b0;
         product <= 16'h0000;
         cand <= 8'h00;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            busy <= 1'b1;
            count <= 4'd1;
            cand <= mcand;
            product <= {8'h00, mplier};
         end else if (busy) begin
            if (count <= 4'd8) begin
               // One add then shift per bit
               product <= product[0] ?
                  {({1'b0, product[15:8]} + {1'b0, cand}), product[7:1]} :
                  {1'b0, product[15:1]};
            end
            // Done one early so the result lands on the eleventh edge
            if (count == (`CRG_MUL_CYCLES - 4'd1)) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
            count <= count + 4'd1;
         end
      end
   end
endmodule : crg_mul
`default_nettype wire

/* rtl/crg_core.sv */
// CPU register set and addressing datapath behind an Avalon-MM slave.
// Assumes a single-clock master that holds each request until waitrequest low.
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`include "crg_map.svh"
`default_nettype none
module crg_core
   import crg_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Avalon-MM slave
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Interrupt request from peripherals
   input wire logic irq_req,
   // Status
   output logic irq_pending
);
   logic [7:0] accumulator_reg;
   logic [7:0] index_reg;
   logic [5:0] sp_low;
   logic [15:0] program_counter_reg;
   logic [4:0] ccr_bits; // H I N Z C
   logic [15:0] opnd;
   logic [15:0] ea_reg;
   logic [1:0] len_reg;
   logic answered;
   crg_state_t state;
   logic [15:0] stack_pointer_reg;
   logic [7:0] condition_code_reg;
   logic wr_go;
   crg_cmd_t cmd;
   crg_mode_t cmd_mode;
   logic [15:0] ea_addr;
   logic [1:0] ea_len;
   logic mul_start;
   logic mul_busy;
   logic mul_done;
   logic [15:0] mul_product;
   logic [8:0] alu_sum;
   logic [4:0] alu_half;
   logic [7:0] alu_res;
   logic alu_do;

   // Assembled views of fixed-bit registers
   assign stack_pointer_reg = {`CRG_SP_FIXED, sp_low};
   assign condition_code_reg = {`CRG_CCR_FIXED, ccr_bits};

   // Decode helper used by the write path; reads decode the address in a case
   function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
      hit = (a == off);
   endfunction : hit

   // One wait state per access, busy multiply stalls every access
   assign waitrequest = (read | write) & (~answered | (state == CRG_ST_MUL));
   assign wr_go = write & ~waitrequest;
   assign cmd = crg_cmd_t'(writedata[3:0]);
   assign cmd_mode = crg_mode_t'(writedata[6:4]);

   // Wait-state toggle, held off while multiply runs so read data are fresh
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         answered <= 1'b0;
      end else begin
         answered <= (read | write) & ~answered & (state != CRG_ST_MUL);
      end
   end

   // Address generator reads the operand register; branch condition comes from command bit 7
   crg_ea u_ea (
      .mode(cmd_mode),
      .index(index_reg),
      .byte1(opnd[15:8]),
      .byte2(opnd[7:0]),
      .next_pc(program_counter_reg),
      .cond(writedata[7]),
      .eff_addr(ea_addr),
      .length(ea_len)
   );

   assign mul_start = wr_go & hit(address, `CRG_OFF_CMD) & (cmd == CRG_CMD_MUL);

   crg_mul u_mul (
      .clk(clk),
      .sys_rst(sys_rst),
      .start(mul_start),
      .mcand(accumulator_reg),
      .mplier(index_reg),
      .busy(mul_busy),
      .done(mul_done),
      .product(mul_product)
   );

   // Multiply state tracks the sequencer
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= CRG_ST_IDLE;
      end else begin
         case (state)
            CRG_ST_IDLE: if (mul_start) state <= CRG_ST_MUL;
            CRG_ST_MUL: if (mul_done) state <= CRG_ST_IDLE;
            default: state <= CRG_ST_IDLE;
         endcase
      end
   end

   // ALU: addition with carry-in, subtraction with the borrow out in bit 8
   always_comb begin
      alu_sum = 9'h000;
      alu_half = 5'h00;
      alu_res = 8'h00;
      alu_do = 1'b0;
      case (cmd)
         CRG_CMD_ADD, CRG_CMD_ADC: begin
            alu_sum = {1'b0, accumulator_reg} + {1'b0, writedata[15:8]} +
               {8'h00, (cmd == CRG_CMD_ADC) & ccr_bits[`CRG_CCR_C]};
            alu_half = {1'b0, accumulator_reg[3:0]} + {1'b0, writedata[11:8]} +
               {4'h0, (cmd == CRG_CMD_ADC) & ccr_bits[`CRG_CCR_C]};
            alu_res = alu_sum[7:0];
            alu_do = 1'b1;
         end
         CRG_CMD_SUB: begin
            alu_sum = {1'b0, accumulator_reg} - {1'b0, writedata[15:8]};
            alu_res = alu_sum[7:0];
            alu_do = 1'b1;
         end
         CRG_CMD_AND: begin
            alu_res = accumulator_reg & writedata[15:8];
            alu_do = 1'b1;
         end
         CRG_CMD_LDA: begin
            alu_res = writedata[15:8];
            alu_do = 1'b1;
         end
         default: alu_do = 1'b0;
      endcase
   end

   // Accumulator and index register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         accumulator_reg <= 8'h00;
         index_reg <= 8'h00;
      end else if (mul_done) begin
         accumulator_reg <= mul_product[7:0];
         index_reg <= mul_product[15:8];
      end else if (wr_go && hit(address, `CRG_OFF_ACC)) begin
         accumulator_reg <= writedata[7:0];
      end else if (wr_go && hit(address, `CRG_OFF_IDX)) begin
         index_reg <= writedata[7:0];
      end else if (wr_go && hit(address, `CRG_OFF_CMD) && alu_do) begin
         accumulator_reg <= alu_res;
      end
   end

   // Stack pointer: only the low six bits move
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sp_low <= 6'h3f;
      end else if (wr_go && hit(address, `CRG_OFF_CMD)) begin
         case (cmd)
            CRG_CMD_RSP: sp_low <= 6'h3f;
            CRG_CMD_PUSH: sp_low <= sp_low - 6'd1;
            CRG_CMD_PULL: sp_low <= sp_low + 6'd1;
            CRG_CMD_IRQ: sp_low <= sp_low - 6'd5;
            CRG_CMD_RTI: sp_low <= sp_low + 6'd5;
            default: sp_low <= sp_low;
         endcase
      end
   end

   // Program counter: top two bits kept zero
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         program_counter_reg <= 16'h0000;
      end else if (wr_go && hit(address, `CRG_OFF_PC)) begin
         program_counter_reg <= writedata[15:0] & `CRG_PC_MASK;
      end else if (wr_go && hit(address, `CRG_OFF_CMD)) begin
         case (cmd)
            CRG_CMD_FETCH: program_counter_reg <=
               (program_counter_reg + {14'h0, ea_len}) & `CRG_PC_MASK;
            CRG_CMD_BRANCH: program_counter_reg <= ea_addr & `CRG_PC_MASK;
            CRG_CMD_JUMP, CRG_CMD_IRQ: program_counter_reg <= opnd & `CRG_PC_MASK;
            default: program_counter_reg <= program_counter_reg;
         endcase
      end
   end

   // Condition code flags
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ccr_bits <= 5'h08;
      end else if (mul_done) begin
         ccr_bits[`CRG_CCR_H] <= 1'b0;
         ccr_bits[`CRG_CCR_C] <= 1'b0;
      end else if (wr_go && hit(address, `CRG_OFF_CCR)) begin
         ccr_bits <= writedata[4:0];
      end else if (wr_go && hit(address, `CRG_OFF_CMD)) begin
         if (cmd == CRG_CMD_IRQ) begin
            ccr_bits[`CRG_CCR_I] <= 1'b1;
         end else if (cmd == CRG_CMD_RTI) begin
            ccr_bits[`CRG_CCR_I] <= 1'b0;
         end else if (alu_do) begin
            ccr_bits[`CRG_CCR_N] <= alu_res[7];
            ccr_bits[`CRG_CCR_Z] <= (alu_res == 8'h00);
            if (cmd == CRG_CMD_ADD || cmd == CRG_CMD_ADC) begin
               ccr_bits[`CRG_CCR_H] <= alu_half[4];
            end
            if (cmd != CRG_CMD_LDA && cmd != CRG_CMD_AND) begin
               ccr_bits[`CRG_CCR_C] <= alu_sum[8];
            end
         end
      end
   end

   // Pending interrupt latch; a new request wins over servicing
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_pending <= 1'b0;
      end else if (irq_req) begin
         irq_pending <= 1'b1;
      end else if (wr_go && hit(address, `CRG_OFF_CMD) && cmd == CRG_CMD_IRQ) begin
         irq_pending <= 1'b0;
      end
   end

   // Operand bytes and last address result
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         opnd <= 16'h0000;
         ea_reg <= 16'h0000;
         len_reg <= 2'd0;
      end else if (wr_go && hit(address, `CRG_OFF_OPND)) begin
         opnd <= writedata[15:0];
      end else if (wr_go && hit(address, `CRG_OFF_CMD) && cmd == CRG_CMD_EA) begin
         ea_reg <= ea_addr;
         len_reg <= ea_len;
      end
   end

   // Read data loaded in the wait cycle, so they stand at the answering edge
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         readdata <= 32'h0000_0000;
      end else if (read & ~answered) begin
         case (address)
            `CRG_OFF_ACC: readdata <= {24'h000000, accumulator_reg};
            `CRG_OFF_IDX: readdata <= {24'h000000, index_reg};
            `CRG_OFF_SP: readdata <= {16'h0000, stack_pointer_reg};
            `CRG_OFF_PC: readdata <= {16'h0000, program_counter_reg};
            `CRG_OFF_CCR: readdata <= {24'h000000, condition_code_reg};
            `CRG_OFF_CMD: readdata <= {30'h0, irq_pending, mul_busy};
            `CRG_OFF_OPND: readdata <= {16'h0000, opnd};
            `CRG_OFF_EA: readdata <= {14'h0, len_reg, ea_reg};
            default: readdata <= 32'h0000_0000;
         endcase
      end
   end

   // Stack pointer never leaves its window
   sp_window_a: assert property (@(posedge clk) disable iff (sys_rst)
      stack_pointer_reg[15:6] == 10'h003) else $error("stack pointer left window");
   // Fixed condition code bits
   ccr_fixed_a: assert property (@(posedge clk) disable iff (sys_rst)
      condition_code_reg[7:5] == 3'h7) else $error("ccr top bits not ones");
   // Reload returns pointer to top
   sp_reload_a: assert property (@(posedge clk) disable iff (sys_rst)
      wr_go && address == `CRG_OFF_CMD && cmd == CRG_CMD_RSP
      |=> stack_pointer_reg == 16'h00ff) else $error("reload missed");
   // Push moves pointer down by one
   sp_push_a: assert property (@(posedge clk) disable iff (sys_rst)
      wr_go && address == `CRG_OFF_CMD && cmd == CRG_CMD_PUSH
      |=> sp_low == $past(sp_low) - 6'd1) else $error("push step wrong");
   // Program counter top bits clear
   pc_top_a: assert property (@(posedge clk) disable iff (sys_rst)
      program_counter_reg[15:14] == 2'b00) else $error("pc top bits set");
   // Multiply finishes eleven clocks after start
   mul_len_a: assert property (@(posedge clk) disable iff (sys_rst)
      mul_start |-> ##11 mul_done) else $error("multiply length wrong");
   // Interrupt entry sets mask
   irq_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
      wr_go && address == `CRG_OFF_CMD && cmd == CRG_CMD_IRQ
      |=> ccr_bits[`CRG_CCR_I]) else $error("mask not set");
   // Zero flag follows loaded value
   zero_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
      wr_go && address == `CRG_OFF_CMD && cmd == CRG_CMD_LDA
      |=> ccr_bits[`CRG_CCR_Z] == (accumulator_reg == 8'h00)) else $error("zero flag wrong");
   // Request latched while masked
   irq_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
      irq_req |=> irq_pending) else $error("request lost");
   // Pull moves pointer up by one
   sp_pull_a: assert property (@(posedge clk) disable iff (sys_rst)
      wr_go && address == `CRG_OFF_CMD && cmd == CRG_CMD_PULL
      |=> sp_low == $past(sp_low) + 6'd1) else $error("pull step wrong");
   // Interrupt entry takes a five byte frame
   irq_frame_a: assert property (@(posedge clk) disable iff (sys_rst)
      wr_go && address == `CRG_OFF_CMD && cmd == CRG_CMD_IRQ
      |=> sp_low == $past(sp_low) - 6'd5) else $error("interrupt frame wrong");
   // Return clears the mask
   rti_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
      wr_go && address == `CRG_OFF_CMD && cmd == CRG_CMD_RTI
      |=> !ccr_bits[`CRG_CCR_I]) else $error("mask not restored");
   // Jump loads the operand address
   pc_jump_a: assert property (@(posedge clk) disable iff (sys_rst)
      wr_go && address == `CRG_OFF_CMD && cmd == CRG_CMD_JUMP
      |=> program_counter_reg == ($past(opnd) & `CRG_PC_MASK)) else $error("jump missed");
   // Product halves land in index and accumulator
   mul_result_a: assert property (@(posedge clk) disable iff (sys_rst)
      mul_done |=> accumulator_reg == $past(mul_product[7:0])
      && index_reg == $past(mul_product[15:8])) else $error("product misplaced");
   // Half carry from the low nibble on add
   half_carry_a: assert property (@(posedge clk) disable iff (sys_rst)
      wr_go && address == `CRG_OFF_CMD && cmd == CRG_CMD_ADD
      |=> ccr_bits[`CRG_CCR_H] == (({1'b0, $past(accumulator_reg[3:0])} +
         {1'b0, $past(writedata[11:8])}) > 5'h0f)) else $error("half carry wrong");
endmodule : crg_core
`default_nettype wire

/* tb/crg_irq_src.sv */
// Peripheral interrupt source standing on the far side of the register block.
// Assumes fire is a one-cycle request from the bench, driven after a rising edge.
`default_nettype none
module crg_irq_src (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Bench control
   input wire logic fire,
   // Request to the core
   output logic irq_req
);
   timeunit 1ns;
   timeprecision 1ps;
   // One-cycle pulse, so only the core's latch can keep it alive
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_req <= 1'b0;
      end else begin
         irq_req <= fire;
      end
   end
endmodule : crg_irq_src
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the CPU register and addressing datapath.
// Assumes crg_core behind an Avalon slave and a pulsed interrupt source.
`include "crg_map.svh"
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("ERROR %s expected %h seen %h", nm, (exp), (got)); end end
module testbench;
   import crg_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, sys_rst, read, write, waitrequest, irq_req, irq_pending, irq_fire;
   logic [4:0] address;
   logic [31:0] writedata, readdata, q;
   logic [3:0] byteenable;
   int error_cnt, checks, cyc, t0;
   crg_core dut_u (.clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .irq_req(irq_req), .irq_pending(irq_pending));
   crg_irq_src irq_u (.clk(clk), .sys_rst(sys_rst), .fire(irq_fire), .irq_req(irq_req));
   // Clock and hang guard
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   task report_and_stop();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop
   // Held until waitrequest samples low; an idle cycle follows so strobes never rebound
   task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      address <= a;
      writedata <= d;
      write <= wr;
      read <= ~wr;
      @(posedge clk);
      while (waitrequest !== 1'b0 && n < 300) begin
         @(posedge clk);
         n++;
      end
      if (n >= 300) error_cnt++;
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge clk);
   endtask : bus
   task cmd(input crg_cmd_t c, input crg_mode_t m, input logic cond, input logic [7:0] dat);
      bus(1'b1, `CRG_OFF_CMD, {16'h0000, dat, cond, m, c});
   endtask : cmd
   task t_regs();
      bus(1'b0, `CRG_OFF_SP, 32'h0); `CHK("sp reset", 16'h00ff, q[15:0])
      bus(1'b0, `CRG_OFF_CCR, 32'h0); `CHK("ccr reset", 8'he8, q[7:0])
      bus(1'b1, `CRG_OFF_SP, 32'h1234);
      bus(1'b0, `CRG_OFF_SP, 32'h0); `CHK("sp read only", 16'h00ff, q[15:0])
      bus(1'b1, `CRG_OFF_CCR, 32'h0);
      bus(1'b0, `CRG_OFF_CCR, 32'h0); `CHK("ccr fixed", 8'he0, q[7:0])
      bus(1'b1, `CRG_OFF_ACC, 32'h5a);
      bus(1'b1, `CRG_OFF_IDX, 32'ha5);
      bus(1'b0, `CRG_OFF_ACC, 32'h0); `CHK("acc", 8'h5a, q[7:0])
      bus(1'b0, `CRG_OFF_IDX, 32'h0); `CHK("idx", 8'ha5, q[7:0])
      bus(1'b0, 5'h02, 32'h0); `CHK("unmapped", 32'h0, q)
   endtask : t_regs
   task t_stack();
      cmd(CRG_CMD_PUSH, CRG_AM_INH, 1'b0, 8'h0);
      bus(1'b0, `CRG_OFF_SP, 32'h0); `CHK("sp push", 16'h00fe, q[15:0])
      for (int i = 0; i < 63; i++) cmd(CRG_CMD_PUSH, CRG_AM_INH, 1'b0, 8'h0);
      bus(1'b0, `CRG_OFF_SP, 32'h0); `CHK("sp wrap", 16'h00ff, q[15:0])
      cmd(CRG_CMD_PULL, CRG_AM_INH, 1'b0, 8'h0);
      bus(1'b0, `CRG_OFF_SP, 32'h0); `CHK("sp pull", 16'h00c0, q[15:0])
      cmd(CRG_CMD_RSP, CRG_AM_INH, 1'b0, 8'h0);
      bus(1'b0, `CRG_OFF_SP, 32'h0); `CHK("sp reload", 16'h00ff, q[15:0])
   endtask : t_stack
   task t_alu();
      cmd(CRG_CMD_LDA, CRG_AM_IMM, 1'b0, 8'h0f);
      cmd(CRG_CMD_ADD, CRG_AM_IMM, 1'b0, 8'h01);
      bus(1'b0, `CRG_OFF_CCR, 32'h0); `CHK("half carry", 8'hf0, q[7:0] & 8'hf7)
      cmd(CRG_CMD_ADD, CRG_AM_IMM, 1'b0, 8'hf0);
      bus(1'b0, `CRG_OFF_CCR, 32'h0); `CHK("carry zero", 8'he3, q[7:0] & 8'hf7)
      cmd(CRG_CMD_SUB, CRG_AM_IMM, 1'b0, 8'h01);
      bus(1'b0, `CRG_OFF_CCR, 32'h0); `CHK("borrow neg", 8'he5, q[7:0] & 8'he7)
      cmd(CRG_CMD_ADC, CRG_AM_IMM, 1'b0, 8'h00);
      bus(1'b0, `CRG_OFF_CCR, 32'h0); `CHK("adc flags", 8'hf3, q[7:0] & 8'hf7)
      bus(1'b0, `CRG_OFF_ACC, 32'h0); `CHK("adc result", 8'h00, q[7:0])
      cmd(CRG_CMD_LDA, CRG_AM_IMM, 1'b0, 8'hf0);
      cmd(CRG_CMD_AND, CRG_AM_IMM, 1'b0, 8'h80);
      cmd(CRG_CMD_NOP, CRG_AM_INH, 1'b0, 8'h00);
      bus(1'b0, `CRG_OFF_ACC, 32'h0); `CHK("and result", 8'h80, q[7:0])
      bus(1'b0, `CRG_OFF_CCR, 32'h0); `CHK("and flags", 2'b10, q[2:1])
   endtask : t_alu
   task t_mul();
      bus(1'b1, `CRG_OFF_ACC, 32'hff);
      bus(1'b1, `CRG_OFF_IDX, 32'hff);
      cmd(CRG_CMD_MUL, CRG_AM_INH, 1'b0, 8'h0);
      t0 = cyc;
      bus(1'b0, `CRG_OFF_ACC, 32'h0); `CHK("mul low", 8'h01, q[7:0])
      `CHK("mul stall", 1'b1, (cyc - t0) >= 11)
      bus(1'b0, `CRG_OFF_IDX, 32'h0); `CHK("mul high", 8'hfe, q[7:0])
   endtask : t_mul
   task t_ea();
      logic [15:0] opd [8];
      logic [15:0] eax [8];
      logic [1:0] len [8];
      opd = '{16'hff34, 16'hff34, 16'hff34, 16'hff34, 16'hff34, 16'hff34, 16'h1234, 16'h0};
      eax = '{16'h0, 16'h0, 16'h00ff, 16'hff34, 16'h00ff, 16'h01fe, 16'h1333, 16'h0};
      len = '{2'd1, 2'd2, 2'd2, 2'd3, 2'd1, 2'd2, 2'd3, 2'd2};
      bus(1'b1, `CRG_OFF_IDX, 32'hff);
      // Every mode, lengths always and addresses for the direct through two-byte indexed modes
      for (int m = 0; m < 8; m++) begin
         bus(1'b1, `CRG_OFF_OPND, {16'h0, opd[m]});
         cmd(CRG_CMD_EA, crg_mode_t'(m), 1'b0, 8'h0);
         bus(1'b0, `CRG_OFF_EA, 32'h0);
         `CHK("ea length", len[m], q[17:16])
         if (m >= 2 && m <= 6) `CHK("ea addr", eax[m], q[15:0])
      end
   endtask : t_ea
   task t_flow();
      bus(1'b1, `CRG_OFF_OPND, 32'h1000);
      cmd(CRG_CMD_JUMP, CRG_AM_EXT, 1'b0, 8'h0);
      cmd(CRG_CMD_FETCH, CRG_AM_EXT, 1'b0, 8'h0);
      bus(1'b0, `CRG_OFF_PC, 32'h0); `CHK("pc fetch", 16'h1003, q[15:0])
      bus(1'b1, `CRG_OFF_OPND, 32'h8000);
      cmd(CRG_CMD_BRANCH, CRG_AM_REL, 1'b1, 8'h0);
      bus(1'b0, `CRG_OFF_PC, 32'h0); `CHK("branch back", 16'h0f83, q[15:0])
      bus(1'b1, `CRG_OFF_OPND, 32'h7f00);
      cmd(CRG_CMD_BRANCH, CRG_AM_REL, 1'b1, 8'h0);
      bus(1'b0, `CRG_OFF_PC, 32'h0); `CHK("branch fwd", 16'h1002, q[15:0])
      cmd(CRG_CMD_BRANCH, CRG_AM_REL, 1'b0, 8'h0);
      bus(1'b0, `CRG_OFF_PC, 32'h0); `CHK("branch not taken", 16'h1002, q[15:0])
      bus(1'b1, `CRG_OFF_OPND, 32'hc010);
      cmd(CRG_CMD_JUMP, CRG_AM_EXT, 1'b0, 8'h0);
      cmd(CRG_CMD_FETCH, CRG_AM_INH, 1'b0, 8'h0);
      bus(1'b0, `CRG_OFF_PC, 32'h0); `CHK("pc low bits", 16'h0011, q[15:0] & 16'h3fff)
   endtask : t_flow
   task t_irq();
      bus(1'b1, `CRG_OFF_CCR, 32'h08);
      irq_fire <= 1'b1;
      @(posedge clk);
      irq_fire <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK("irq latched", 1'b1, irq_pending)
      bus(1'b0, `CRG_OFF_CMD, 32'h0); `CHK("irq status", 1'b1, q[1])
      bus(1'b1, `CRG_OFF_OPND, 32'h3ff8);
      cmd(CRG_CMD_IRQ, CRG_AM_INH, 1'b0, 8'h0);
      bus(1'b0, `CRG_OFF_SP, 32'h0); `CHK("irq stack", 16'h00fa, q[15:0])
      bus(1'b0, `CRG_OFF_CCR, 32'h0); `CHK("irq mask", 1'b1, q[3])
      bus(1'b0, `CRG_OFF_PC, 32'h0); `CHK("irq vector", 16'h3ff8, q[15:0])
      `CHK("irq served", 1'b0, irq_pending)
      cmd(CRG_CMD_RTI, CRG_AM_INH, 1'b0, 8'h0);
      bus(1'b0, `CRG_OFF_SP, 32'h0); `CHK("rti stack", 16'h00ff, q[15:0])
      bus(1'b0, `CRG_OFF_CCR, 32'h0); `CHK("rti mask", 1'b0, q[3])
   endtask : t_irq
   // Reset in mid-run after moving the pointer and clearing the mask
   task t_reset();
      cmd(CRG_CMD_PUSH, CRG_AM_INH, 1'b0, 8'h0);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      bus(1'b0, `CRG_OFF_SP, 32'h0); `CHK("sp rerun", 16'h00ff, q[15:0])
      bus(1'b0, `CRG_OFF_CCR, 32'h0); `CHK("ccr rerun", 8'he8, q[7:0])
   endtask : t_reset
   // Main sequence
   initial begin
      clk = 1'b0;
      sys_rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 5'h00;
      writedata = 32'h0;
      byteenable = 4'hf;
      irq_fire = 1'b0;
      error_cnt = 0;
      checks = 0;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_stack();
      t_alu();
      t_mul();
      t_ea();
      t_flow();
      t_irq();
      t_reset();
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
